/* hw/dfs_mb_check.sv */
// Modbus command checker: one registered verdict per decoded frame.
// Assumes frames arrive already decoded, one valid cycle each, synchronous to clk_i.
`timescale 1ns/10ps
module dfs_mb_check (
  input wire logic clk_i, // System clock
  input wire logic rst_b_i, // Async reset, active low
  input wire dfs_pkg::dfs_mb_frame_t frame_i, // Decoded frame
  input wire logic [15:0] val_min_i, // Lowest legal written value
  input wire logic [15:0] val_max_i, // Highest legal written value
  input wire logic [15:0] ro_base_i, // First read-only address
  output logic [3:0] err_o, // Pulse: fn, addr, value, read-only
  output dfs_pkg::dfs_mb_wr_t wr_o // Accepted write pulse
);
  import dfs_pkg::*;

  logic [3:0] err_ff;
  dfs_mb_wr_t wr_ff;

  wire is_write = (frame_i.func == MB_FN_WRITE1) || (frame_i.func == MB_FN_WRITEN);
  wire bad_fn = !(is_write || frame_i.func == MB_FN_READ || frame_i.func == MB_FN_LOOP);
  wire bad_addr = !bad_fn && (frame_i.addr > MB_ADDR_MAX);
  wire bad_ro = !bad_fn && !bad_addr && is_write && (frame_i.addr >= ro_base_i);
  wire bad_val = !bad_fn && !bad_addr && !bad_ro && is_write &&
                 ((frame_i.data < val_min_i) || (frame_i.data > val_max_i));
  wire ok_wr = is_write && !bad_fn && !bad_addr && !bad_ro && !bad_val;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      err_ff <= 4'h0;
      wr_ff <= '0;
    end else begin
      err_ff <= frame_i.valid ? {bad_ro, bad_val, bad_addr, bad_fn} : 4'h0;
      wr_ff <= '{valid: frame_i.valid && ok_wr, addr: frame_i.addr, data: frame_i.data};
    end
  end

  assign err_o = err_ff;
  assign wr_o = wr_ff;

  chk_mb_bad_fn: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    frame_i.valid && bad_fn |=> err_o[0] && !wr_o.valid) else $error("bad function not flagged");
  chk_mb_bad_addr: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    frame_i.valid && !bad_fn && frame_i.addr > MB_ADDR_MAX |=> err_o[1]) else $error("bad address missed");
  chk_mb_ro_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    frame_i.valid && is_write && bad_ro |=> err_o[3] && !wr_o.valid) else $error("read-only write leaked");
  chk_mb_value_range: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_o.valid |-> wr_o.data >= $past(val_min_i) && wr_o.data <= $past(val_max_i))
    else $error("out of range value accepted");

endmodule // dfs_mb_check

/* hw/dfs_pkg.sv */
// Package of the drive fault supervisor: register map, fault codes, source table and bus carriers.
// Assumes one 125 MHz clock shared by every user of these constants.
package dfs_pkg;

  // Clock and slow tick timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [7:0] REG_FAULT_CODE = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_CTRL = 8'h0C;
  localparam logic [7:0] REG_TIMEOUT = 8'h10;
  localparam logic [7:0] REG_SLIP_LEVEL = 8'h14;
  localparam logic [7:0] REG_SLIP_TIME = 8'h18;
  localparam logic [7:0] REG_DEB_CFG = 8'h1C;
  localparam logic [7:0] REG_VAL_MIN = 8'h20;
  localparam logic [7:0] REG_VAL_MAX = 8'h24;
  localparam logic [7:0] REG_RO_BASE = 8'h28;
  localparam logic [7:0] REG_ACTIVE = 8'h2C;

  // Field positions and reset values
  localparam int CTRL_RESET_BIT = 0;
  localparam logic [15:0] TIMEOUT_RST = 16'h0000;
  localparam logic [15:0] SLIP_LEVEL_RST = 16'hFFFF;
  localparam logic [15:0] SLIP_TIME_RST = 16'h0064;
  localparam logic [15:0] DEB_CFG_RST = 16'h0000;
  localparam logic [15:0] VAL_MIN_RST = 16'h0000;
  localparam logic [15:0] VAL_MAX_RST = 16'hFFFF;
  localparam logic [15:0] RO_BASE_RST = 16'h0200;

  // Analog current floor in microamps, password tries
  localparam logic [15:0] ACI_MIN_UA = 16'd4000;
  localparam logic [1:0] PW_MAX_WRONG = 2'd3;

  // Modbus function codes and address span
  localparam logic [7:0] MB_FN_READ = 8'h03;
  localparam logic [7:0] MB_FN_WRITE1 = 8'h06;
  localparam logic [7:0] MB_FN_WRITEN = 8'h10;
  localparam logic [7:0] MB_FN_LOOP = 8'h63;
  localparam logic [15:0] MB_ADDR_MAX = 16'h0254;

  // Fault sources, one bit each
  localparam int NSRC = 15;
  typedef enum logic [3:0] {
    SRC_ACI = 4'h0, SRC_EXT = 4'h1, SRC_ESTOP = 4'h2, SRC_BB = 4'h3, SRC_PW = 4'h4,
    SRC_MB_FN = 4'h5, SRC_MB_ADDR = 4'h6, SRC_MB_VAL = 4'h7, SRC_MB_RO = 4'h8,
    SRC_TMO = 4'h9, SRC_DEB = 4'hA, SRC_OSL = 4'hB, SRC_STLA = 4'hC, SRC_STO = 4'hD, SRC_STLB = 4'hE
  } dfs_src_t;

  // How each source recovers
  typedef enum logic [1:0] {CLR_LEVEL = 2'h0, CLR_CMD = 2'h1, CLR_POWER = 2'h3} dfs_clr_t;

  localparam logic [7:0] SRC_CODE [NSRC] = '{8'd48, 8'd49, 8'd50, 8'd51, 8'd52, 8'd54, 8'd55, 8'd56,
                                             8'd57, 8'd58, 8'd62, 8'd63, 8'd72, 8'd76, 8'd77};
  localparam dfs_clr_t SRC_CLR [NSRC] = '{CLR_CMD, CLR_CMD, CLR_CMD, CLR_LEVEL, CLR_POWER, CLR_CMD,
                                          CLR_CMD, CLR_CMD, CLR_CMD, CLR_CMD, CLR_LEVEL, CLR_CMD,
                                          CLR_POWER, CLR_POWER, CLR_POWER};
  // Sources that stop the output stage
  localparam logic [NSRC-1:0] INHIBIT_MASK = 15'h780F;

  typedef struct packed {
    logic valid;
    logic [7:0] func;
    logic [15:0] addr;
    logic [15:0] data;
  } dfs_mb_frame_t;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [15:0] data;
  } dfs_mb_wr_t;

endpackage

/* hw/dfs_top.sv */
// Drive fault supervisor: watches terminals, safety channels, analog loss, slip and Modbus commands,
// latches numbered faults, stops the output stage and holds the keypad lock-out.
// Assumes all inputs synchronous to clk_i; power cycle is rst_b_i.
//
// What this block does
// - An active external-fault terminal stops the output and latches code 49 until a reset command after it goes away.
// - An active emergency-stop terminal stops the output and latches code 50 until a reset command after it goes away.
// - The base-block terminal suppresses the output and shows code 51 only while it is active.
// - The third wrong keypad password in a row locks the keypad with code 52 until power is cycled.
// - Modbus function codes other than 03, 06, 10 and 63 raise code 54.
// - Modbus data addresses above 254H raise code 55.
// - A written Modbus value outside its minimum and maximum is refused with code 56.
// - A Modbus write to a read-only address is refused with code 57 and changes nothing.
// - When no Modbus command arrives within the set time-out, code 58 is raised.
// - With a nonzero energy-backup setting a momentary power loss shows code 62 during the stop.
// - Slip above its threshold for longer than its set time raises code 63.
// - Analog current input below 4 mA raises code 48.
// - An internal error on safety channel A raises code 72, recovered only by a power cycle.
// - Safe torque off through both safety inputs removes torque and reports code 76 until a power cycle.
// - An internal error on safety channel B raises code 77, recovered only by a power cycle.
`timescale 1ns/10ps
module dfs_top #(
  parameter int TICK_CYC = dfs_pkg::TICK_CYCLES // Cycles per millisecond tick
) (
  input wire logic clk_i, // 125 MHz clock
  input wire logic rst_b_i, // Power-on reset, active low
  input wire logic [7:0] addr_i, // Register byte address
  input wire logic [31:0] wdata_i, // Register write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [31:0] rdata_o, // Read data, cycle after rd_i
  input wire logic external_fault_input_i, // External fault terminal
  input wire logic emergency_stop_input_i, // Emergency stop terminal
  input wire logic base_block_input_i, // Base block terminal
  input wire logic pw_entry_i, // Pulse: password entered
  input wire logic pw_ok_i, // Entered password matches
  input wire dfs_pkg::dfs_mb_frame_t mb_frame_i, // Decoded Modbus frame
  input wire logic [15:0] analog_current_input_i, // Analog current in microamps
  input wire logic [15:0] slip_i, // Measured motor slip
  input wire logic power_loss_i, // Momentary power loss seen
  input wire logic decel_stop_i, // Accel/decel stop in progress
  input wire logic safety_input_a_i, // Safety input A, high = run
  input wire logic safety_input_b_i, // Safety input B, high = run
  input wire logic safety_channel_a_fault_i, // Channel A hardware error
  input wire logic safety_channel_b_fault_i, // Channel B hardware error
  output logic output_inhibit_o, // Output stage stopped
  output logic keypad_lock_o, // Keypad locked out
  output logic [7:0] fault_code_o, // Latest fault code, 0 if none
  output dfs_pkg::dfs_mb_wr_t mb_wr_o, // Accepted Modbus write
  output logic [3:0] mb_err_o, // Modbus exception pulses
  output logic irq_o // Level interrupt
);
  import dfs_pkg::*;

  // Registers
  logic [NSRC-1:0] active_ff, status_ff, mask_ff;
  logic [15:0] timeout_ff, slip_level_ff, slip_time_ff, deb_cfg_ff, val_min_ff, val_max_ff, ro_base_ff;
  logic [31:0] rdata_ff;
  logic [16:0] tick_cnt_ff;
  logic tick_ff;
  logic [15:0] tmo_cnt_ff, slip_cnt_ff;
  logic [1:0] pw_wrong_ff;
  logic [3:0] cur_src_ff;
  logic cur_valid_ff;
  logic [7:0] code_ff;
  logic inhibit_ff, lock_ff, irq_ff;

  // Register decode
  wire wr_status = wr_i && addr_i == REG_STATUS;
  wire wr_mask = wr_i && addr_i == REG_MASK;
  wire reset_cmd = wr_i && addr_i == REG_CTRL && wdata_i[CTRL_RESET_BIT];
  wire wr_tmo = wr_i && addr_i == REG_TIMEOUT;
  wire wr_slvl = wr_i && addr_i == REG_SLIP_LEVEL;
  wire wr_stime = wr_i && addr_i == REG_SLIP_TIME;
  wire wr_deb = wr_i && addr_i == REG_DEB_CFG;
  wire wr_vmin = wr_i && addr_i == REG_VAL_MIN;
  wire wr_vmax = wr_i && addr_i == REG_VAL_MAX;
  wire wr_rob = wr_i && addr_i == REG_RO_BASE;

  logic [31:0] rd_mux;
  always_comb begin
    case (addr_i)
      REG_FAULT_CODE: rd_mux = {24'h0, code_ff};
      REG_STATUS: rd_mux = {17'h0, status_ff};
      REG_MASK: rd_mux = {17'h0, mask_ff};
      REG_TIMEOUT: rd_mux = {16'h0, timeout_ff};
      REG_SLIP_LEVEL: rd_mux = {16'h0, slip_level_ff};
      REG_SLIP_TIME: rd_mux = {16'h0, slip_time_ff};
      REG_DEB_CFG: rd_mux = {16'h0, deb_cfg_ff};
      REG_VAL_MIN: rd_mux = {16'h0, val_min_ff};
      REG_VAL_MAX: rd_mux = {16'h0, val_max_ff};
      REG_RO_BASE: rd_mux = {16'h0, ro_base_ff};
      REG_ACTIVE: rd_mux = {17'h0, active_ff};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_ff <= 32'h0;
      mask_ff <= '0;
      timeout_ff <= TIMEOUT_RST;
      slip_level_ff <= SLIP_LEVEL_RST;
      slip_time_ff <= SLIP_TIME_RST;
      deb_cfg_ff <= DEB_CFG_RST;
      val_min_ff <= VAL_MIN_RST;
      val_max_ff <= VAL_MAX_RST;
      ro_base_ff <= RO_BASE_RST;
    end else begin
      rdata_ff <= rd_i ? rd_mux : 32'h0;
      if (wr_mask) mask_ff <= wdata_i[NSRC-1:0];
      if (wr_tmo) timeout_ff <= wdata_i[15:0];
      if (wr_slvl) slip_level_ff <= wdata_i[15:0];
      if (wr_stime) slip_time_ff <= wdata_i[15:0];
      if (wr_deb) deb_cfg_ff <= wdata_i[15:0];
      if (wr_vmin) val_min_ff <= wdata_i[15:0];
      if (wr_vmax) val_max_ff <= wdata_i[15:0];
      if (wr_rob) ro_base_ff <= wdata_i[15:0];
    end
  end

  // Millisecond tick
  wire tick_wrap = tick_cnt_ff == 17'(TICK_CYC - 1);
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_cnt_ff <= 17'h0;
      tick_ff <= 1'b0;
    end else begin
      tick_cnt_ff <= tick_wrap ? 17'h0 : tick_cnt_ff + 17'h1;
      tick_ff <= tick_wrap;
    end
  end

  // Modbus checks
  logic [3:0] mb_err;
  dfs_mb_check u_mb_check (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .frame_i(mb_frame_i),
    .val_min_i(val_min_ff),
    .val_max_i(val_max_ff),
    .ro_base_i(ro_base_ff),
    .err_o(mb_err),
    .wr_o(mb_wr_o)
  );
  assign mb_err_o = mb_err;

  wire tmo_hit = timeout_ff != 16'h0 && tmo_cnt_ff >= timeout_ff;
  wire slip_over = slip_i > slip_level_ff;
  wire slip_hit = slip_over && slip_cnt_ff > slip_time_ff;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tmo_cnt_ff <= 16'h0;
      slip_cnt_ff <= 16'h0;
    end else begin
      if (mb_frame_i.valid) tmo_cnt_ff <= 16'h0;
      else if (tick_ff && tmo_cnt_ff != 16'hFFFF) tmo_cnt_ff <= tmo_cnt_ff + 16'h1;
      if (!slip_over) slip_cnt_ff <= 16'h0;
      else if (tick_ff && slip_cnt_ff != 16'hFFFF) slip_cnt_ff <= slip_cnt_ff + 16'h1;
    end
  end

  wire pw_bad = pw_entry_i && !pw_ok_i && !lock_ff;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) pw_wrong_ff <= 2'h0;
    else if (pw_entry_i && pw_ok_i && !lock_ff) pw_wrong_ff <= 2'h0;
    else if (pw_bad && pw_wrong_ff != PW_MAX_WRONG) pw_wrong_ff <= pw_wrong_ff + 2'h1;
  end

  // Raw condition per source
  logic [NSRC-1:0] cond;
  always_comb begin
    cond = '0;
    cond[SRC_ACI] = analog_current_input_i < ACI_MIN_UA;
    cond[SRC_EXT] = external_fault_input_i;
    cond[SRC_ESTOP] = emergency_stop_input_i;
    cond[SRC_BB] = base_block_input_i;
    cond[SRC_PW] = pw_bad && pw_wrong_ff == PW_MAX_WRONG - 2'h1;
    cond[SRC_MB_FN] = mb_err[0];
    cond[SRC_MB_ADDR] = mb_err[1];
    cond[SRC_MB_VAL] = mb_err[2];
    cond[SRC_MB_RO] = mb_err[3];
    cond[SRC_TMO] = tmo_hit;
    cond[SRC_DEB] = deb_cfg_ff != 16'h0 && power_loss_i && decel_stop_i;
    cond[SRC_OSL] = slip_hit;
    cond[SRC_STLA] = safety_channel_a_fault_i;
    cond[SRC_STO] = !safety_input_a_i && !safety_input_b_i;
    cond[SRC_STLB] = safety_channel_b_fault_i;
  end

  // Per-source latch with its recovery class
  logic [NSRC-1:0] nxt_active;
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_src
      wire keep = active_ff[g] && (SRC_CLR[g] == CLR_POWER ||
                  (SRC_CLR[g] == CLR_CMD && !(reset_cmd && !cond[g])));
      assign nxt_active[g] = cond[g] || (SRC_CLR[g] != CLR_LEVEL && keep);
    end
  endgenerate
  wire [NSRC-1:0] rise = nxt_active & ~active_ff;

  // Newest raised source, highest index wins a tie
  logic [3:0] nxt_src;
  always_comb begin
    nxt_src = cur_src_ff;
    for (int i = 0; i < NSRC; i++) begin
      if (rise[i]) nxt_src = 4'(i);
    end
  end
  wire src_dropped = cur_valid_ff && !nxt_active[cur_src_ff];

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      active_ff <= '0;
      status_ff <= '0;
      cur_src_ff <= 4'h0;
      cur_valid_ff <= 1'b0;
      code_ff <= 8'h00;
    end else begin
      active_ff <= nxt_active;
      // New events win over a write-one clear
      status_ff <= (status_ff & ~(wr_status ? wdata_i[NSRC-1:0] : '0)) | rise;
      if (|rise) begin
        cur_src_ff <= nxt_src;
        cur_valid_ff <= 1'b1;
        code_ff <= SRC_CODE[nxt_src];
      end else if (src_dropped) begin
        cur_valid_ff <= 1'b0;
        code_ff <= 8'h00;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      inhibit_ff <= 1'b0;
      lock_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      inhibit_ff <= |(nxt_active & INHIBIT_MASK);
      lock_ff <= nxt_active[SRC_PW];
      irq_ff <= |(status_ff & mask_ff);
    end
  end

  assign rdata_o = rdata_ff;
  assign output_inhibit_o = inhibit_ff;
  assign keypad_lock_o = lock_ff;
  assign fault_code_o = code_ff;
  assign irq_o = irq_ff;

  sequence s_ext_on;
    external_fault_input_i && !active_ff[SRC_EXT];
  endsequence
  sequence s_stop_latched(int idx);
    active_ff[idx] && output_inhibit_o;
  endsequence

  chk_ext_fault_latch: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_ext_on |=> s_stop_latched(SRC_EXT) ##0 fault_code_o == 8'd49) else $error("external fault not latched");
  chk_ext_fault_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    active_ff[SRC_EXT] && !reset_cmd |=> active_ff[SRC_EXT]) else $error("external fault dropped early");
  chk_estop_latch: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    emergency_stop_input_i |=> s_stop_latched(SRC_ESTOP)) else $error("emergency stop not latched");
  chk_base_block_level: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    active_ff[SRC_BB] == $past(base_block_input_i)) else $error("base block not following input");
  chk_keypad_lock_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    keypad_lock_o |=> keypad_lock_o) else $error("keypad lock released");
  chk_timeout_raise: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    tmo_hit |=> active_ff[SRC_TMO]) else $error("time-out not raised");
  chk_safety_power_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    active_ff[SRC_STLA] |=> active_ff[SRC_STLA] ##1 active_ff[SRC_STLA]) else $error("channel A fault released");
  chk_sto_inhibit: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !safety_input_a_i && !safety_input_b_i |=> output_inhibit_o && active_ff[SRC_STO])
    else $error("torque not removed");
  chk_code_stable: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !(|rise) && !src_dropped |=> $stable(fault_code_o)) else $error("fault code changed without cause");
  chk_deb_disabled: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    deb_cfg_ff == 16'h0 |=> !active_ff[SRC_DEB]) else $error("energy backup shown while disabled");
  chk_slip_raise: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    slip_hit |=> active_ff[SRC_OSL] && output_inhibit_o) else $error("over slip not raised");
  chk_aci_loss: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    analog_current_input_i < ACI_MIN_UA |=> active_ff[SRC_ACI] && output_inhibit_o)
    else $error("analog loss not raised");
  chk_chan_b_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    active_ff[SRC_STLB] |=> active_ff[SRC_STLB]) else $error("channel B fault released");

endmodule // dfs_top

/* test/dfs_mb_host.sv */
// Modbus host model: turns a one-cycle send request into one decoded frame pulse.
// Assumes the requester drives send_i and its fields synchronous to clk_i.
`timescale 1ns/10ps
module dfs_mb_host (
  input wire logic clk_i, // System clock
  input wire logic rst_b_i, // Reset, active low
  input wire logic send_i, // Pulse: send one command
  input wire logic [7:0] func_i, // Function code
  input wire logic [15:0] addr_i, // Data address
  input wire logic [15:0] data_i, // Data value
  output dfs_pkg::dfs_mb_frame_t frame_o // Frame towards the slave
);
  import dfs_pkg::*;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      frame_o <= '0;
    end else if (send_i) begin
      frame_o <= {1'b1, func_i, addr_i, data_i};
    end else begin
      // Idle fields mean nothing, so they are inverted on every idle cycle
      frame_o <= {1'b0, ~frame_o.func, ~frame_o.addr, ~frame_o.data};
    end
  end
endmodule // dfs_mb_host

/* test/tb.sv */
// Self-checking bench of the drive fault supervisor, with a Modbus host model on the far side.
// Assumes a 125 MHz clock and a millisecond tick shortened to 4 cycles.
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  import dfs_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, ext = 1'b0, estop = 1'b0, bb = 1'b0;
  logic pw_entry = 1'b0, pw_ok = 1'b0, ploss = 1'b0, decel = 1'b0, sa = 1'b1, sb = 1'b1, fa = 1'b0, fb = 1'b0;
  logic send = 1'b0, inhibit, lock, irq;
  logic [7:0] addr = 8'h00, hfunc = 8'h00, code;
  logic [15:0] analog_current_input = 16'h0FA0, slip = 16'h0000, haddr = 16'h0000, hdata = 16'h0000;
  logic [31:0] wdata = 32'h0, rdata, seed = 32'h7DCDBBAA;
  logic [3:0] mb_err;
  dfs_mb_frame_t frame;
  dfs_mb_wr_t mb_wr;
  int n_mismatch = 0, check_count = 0, cycles = 0;
  // Value limits programmed before the Modbus scenarios
  localparam logic [15:0] VMIN_T = 16'h0010;
  localparam logic [15:0] VMAX_T = 16'h1000;
  logic [7:0] codes [7] = '{8'd49, 8'd50, 8'd48, 8'd51, 8'd72, 8'd76, 8'd77};
  logic [7:0] ra [8] = '{REG_TIMEOUT, REG_SLIP_LEVEL, REG_SLIP_TIME, REG_DEB_CFG, REG_VAL_MIN, REG_VAL_MAX,
                         REG_RO_BASE, 8'h30};
  logic [15:0] rv [8] = '{TIMEOUT_RST, SLIP_LEVEL_RST, SLIP_TIME_RST, DEB_CFG_RST, VAL_MIN_RST, VAL_MAX_RST,
                          RO_BASE_RST, 16'h0000};
  logic [7:0] fl [8] = '{8'h03, 8'h06, 8'h10, 8'h63, 8'h06, 8'h10, 8'h03, 8'h00};
  logic [7:0] hf [5] = '{8'h63, 8'h03, 8'h06, 8'h06, 8'h10};
  logic [15:0] ha [5] = '{16'h0254, 16'h0255, 16'h01FF, 16'h0040, 16'h0200};
  logic [15:0] hd [5] = '{16'h0000, 16'h0000, 16'h1000, 16'h000F, 16'h0100};

  dfs_mb_host i_dfs_mb_host (.clk_i(clk), .rst_b_i(rst_b), .send_i(send), .func_i(hfunc), .addr_i(haddr),
    .data_i(hdata), .frame_o(frame));
  dfs_top #(.TICK_CYC(4)) i_dfs_top (.clk_i(clk), .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .external_fault_input_i(ext), .emergency_stop_input_i(estop),
    .base_block_input_i(bb), .pw_entry_i(pw_entry), .pw_ok_i(pw_ok), .mb_frame_i(frame),
    .analog_current_input_i(analog_current_input), .slip_i(slip), .power_loss_i(ploss), .decel_stop_i(decel),
    .safety_input_a_i(sa), .safety_input_b_i(sb), .safety_channel_a_fault_i(fa), .safety_channel_b_fault_i(fb),
    .output_inhibit_o(inhibit), .keypad_lock_o(lock), .fault_code_o(code), .mb_wr_o(mb_wr), .mb_err_o(mb_err),
    .irq_o(irq));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected verdict: bit4 accepted write, bits 3:0 exception in checking priority
  function automatic logic [4:0] mb_exp(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d);
    logic w;
    w = (f == 8'h06) || (f == 8'h10);
    if (!(w || f == 8'h03 || f == 8'h63)) return 5'h01;
    if (a > MB_ADDR_MAX) return 5'h02;
    if (w && a >= RO_BASE_RST) return 5'h08;
    if (w && (d < VMIN_T || d > VMAX_T)) return 5'h04;
    return {w, 4'h0};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask

  task automatic reset_cmd();
    wr_reg(REG_CTRL, 32'h1);
  endtask

  task automatic wait_code(input logic [7:0] e);
    for (int i = 0; i < 60 && code !== e; i++) @(posedge clk);
    #1 `CHK(code, e)
  endtask

  task automatic set_src(input int k, input logic v);
    @(posedge clk);
    case (k)
      0: ext <= v;
      1: estop <= v;
      2: analog_current_input <= v ? 16'h0F9F : 16'h0FA0;
      3: bb <= v;
      4: fa <= v;
      5: begin
        sa <= !v;
        sb <= !v;
      end
      default: fb <= v;
    endcase
  endtask

  task automatic pw(input logic ok);
    @(posedge clk);
    pw_entry <= 1'b1;
    pw_ok <= ok;
    @(posedge clk);
    pw_entry <= 1'b0;
  endtask

  task automatic power_cycle();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    cyc(1);
  endtask

  task automatic mb_send(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d);
    logic [4:0] e;
    e = mb_exp(f, a, d);
    @(posedge clk);
    send <= 1'b1;
    hfunc <= f;
    haddr <= a;
    hdata <= d;
    @(posedge clk);
    send <= 1'b0;
    @(posedge clk);
    #1 `CHK(mb_err, e[3:0])
    `CHK(mb_wr.valid, e[4])
    if (e[4]) `CHK({mb_wr.addr, mb_wr.data}, {a, d})
    if (e[3:0] != 4'h0) begin
      cyc(1);
      `CHK(code, e[1] ? 8'd55 : e[2] ? 8'd56 : e[3] ? 8'd57 : 8'd54)
      reset_cmd();
      cyc(1);
      `CHK(code, 8'h00)
    end
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      close_out();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 8; i++) rd_chk(ra[i], {16'h0, rv[i]});
    wr_reg(8'h30, 32'hFFFF);
    wr_reg(REG_FAULT_CODE, 32'hFF);
    rd_chk(8'h30, 32'h0);
    rd_chk(REG_FAULT_CODE, 32'h0);
    wr_reg(REG_MASK, 32'h7FFF);
    rd_chk(REG_MASK, 32'h7FFF);
    // Latched faults: refused reset while active, cleared by reset after
    for (int k = 0; k < 3; k++) begin
      set_src(k, 1'b1);
      cyc(2);
      `CHK(code, codes[k])
      `CHK({inhibit, irq}, 2'b11)
      rd_chk(REG_FAULT_CODE, {24'h0, codes[k]});
      reset_cmd();
      set_src(k, 1'b0);
      cyc(2);
      `CHK(code, codes[k])
      reset_cmd();
      cyc(1);
      `CHK({code, inhibit}, 9'h000)
      wr_reg(REG_STATUS, 32'h7FFF);
      rd_chk(REG_STATUS, 32'h0);
    end
    wr_reg(REG_MASK, 32'h0);
    set_src(3, 1'b1);
    cyc(2);
    `CHK({code, inhibit, irq}, {8'd51, 2'b10})
    wr_reg(REG_MASK, 32'h7FFF);
    cyc(1);
    `CHK(irq, 1'b1)
    set_src(3, 1'b0);
    cyc(2);
    `CHK({code, inhibit, irq}, 10'h001)
    wr_reg(REG_STATUS, 32'h7FFF);
    cyc(1);
    `CHK(irq, 1'b0)
    wr_reg(REG_VAL_MIN, {16'h0, VMIN_T});
    wr_reg(REG_VAL_MAX, {16'h0, VMAX_T});
    for (int i = 0; i < 45; i++) begin
      seed = lfsr(seed);
      if (i < 5) mb_send(hf[i], ha[i], hd[i]);
      else mb_send(seed[15:13] == 3'd7 ? seed[31:24] : fl[seed[15:13]], {6'h0, seed[25:16]}, {3'h0, seed[12:0]});
    end
    mb_send(8'h03, 16'h0000, 16'h0000);
    wr_reg(REG_TIMEOUT, 32'h3);
    #1 `CHK(code, 8'h00)
    wait_code(8'd58);
    wr_reg(REG_TIMEOUT, 32'h0);
    reset_cmd();
    wr_reg(REG_SLIP_LEVEL, 32'h64);
    wr_reg(REG_SLIP_TIME, 32'h2);
    slip <= 16'h0064;
    cyc(20);
    `CHK(code, 8'h00)
    slip <= 16'h0065;
    cyc(4);
    `CHK(code, 8'h00)
    wait_code(8'd63);
    `CHK(inhibit, 1'b1)
    slip <= 16'h0000;
    reset_cmd();
    ploss <= 1'b1;
    decel <= 1'b1;
    cyc(3);
    `CHK(code, 8'h00)
    wr_reg(REG_DEB_CFG, 32'h5);
    cyc(2);
    `CHK({code, inhibit}, {8'd62, 1'b0})
    ploss <= 1'b0;
    cyc(2);
    `CHK(code, 8'h00)
    for (int i = 0; i < 5; i++) pw(i == 2);
    cyc(1);
    `CHK(lock, 1'b0)
    pw(1'b0);
    cyc(1);
    `CHK({lock, code}, {1'b1, 8'd52})
    pw(1'b1);
    reset_cmd();
    cyc(1);
    `CHK(lock, 1'b1)
    for (int k = 4; k < 7; k++) begin
      power_cycle();
      `CHK(lock, 1'b0)
      set_src(k, 1'b1);
      cyc(2);
      `CHK({code, inhibit}, {codes[k], 1'b1})
      set_src(k, 1'b0);
      reset_cmd();
      cyc(2);
      `CHK(code, codes[k])
    end
    power_cycle();
    `CHK(code, 8'h00)
    close_out();
  end
endmodule // tb
